// ### inc/dtc_pkg.sv
// package: constants and types for the dual timer/counter block
package dtc_pkg;

    // ********************************************
    // register map (printed index, byte = 4*index)
    // ********************************************
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] IDX_TIMER_MODE = 8'h89;
    localparam logic [7:0] IDX_COUNT_LOW_ZERO = 8'h8A;
    localparam logic [7:0] IDX_COUNT_HIGH_ZERO = 8'h8B;
    localparam logic [7:0] IDX_COUNT_LOW_ONE = 8'h8C;
    localparam logic [7:0] IDX_COUNT_HIGH_ONE = 8'h8D;
    localparam logic [7:0] IDX_SLEEP_CTRL = 8'h8E;

    // ********************************************
    // field positions
    // ********************************************
    localparam int CTL_RUN_ZERO = 4;
    localparam int CTL_OVF_ZERO = 5;
    localparam int CTL_RUN_ONE = 6;
    localparam int CTL_OVF_ONE = 7;
    localparam int MOD_MODE0_LSB = 0;
    localparam int MOD_SRC0 = 2;
    localparam int MOD_GATE0 = 3;
    localparam int MOD_MODE1_LSB = 4;
    localparam int MOD_SRC1 = 6;
    localparam int MOD_GATE1 = 7;
    localparam int SLP_SOFT = 0;
    localparam int SLP_HARD = 1;

    // ********************************************
    // reset values and timing
    // ********************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int OSC_PERIOD_NS = 10;
    localparam int MC_PERIOD_NS = 120;
    localparam int OSC_PER_MC = MC_PERIOD_NS / OSC_PERIOD_NS;
    localparam logic [3:0] PHASE_LAST = 4'(OSC_PER_MC - 1);
    localparam logic [3:0] PHASE_S3 = 4'h4;
    localparam logic [3:0] PHASE_S5 = 4'h8;

    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD,
        MODE_SPLIT
    } dtc_mode_e;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic carry;
    } dtc_cnt_s;

    typedef struct packed {
        logic [1:0] count_pin;
        logic [1:0] gate_pin;
    } dtc_pins_s;

endpackage

// ### verilog/dtc_top.sv
// dual timer/counter with AHB-Lite register access
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module dtc_top
    import dtc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire dtc_pins_s pins,
    output logic serial_clk_tick,
    output logic wake_pulse
);

    // ********************************************
    // bus slave
    // ********************************************
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic addr_ok_q;
    logic take;
    logic [7:0] ctl_q;
    logic [7:0] mod_q;
    logic [7:0] lo0_q;
    logic [7:0] hi0_q;
    logic [7:0] lo1_q;
    logic [7:0] hi1_q;
    logic [1:0] slp_q;
    logic [7:0] rd_mux;
    logic [7:0] wd;
    logic wr_ctl;
    logic wr_mod;
    logic wr_lo0;
    logic wr_hi0;
    logic wr_lo1;
    logic wr_hi1;
    logic wr_slp;

    // hsize is not checked: only whole-word transfers are expected
    assign take = hsel && htrans[1] && hready;
    assign wd = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            addr_ok_q <= 1'b0;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take) begin
                addr_q <= haddr[9:2];
                addr_ok_q <= (haddr[31:10] == 22'h000000);
            end
        end
    end

    // reads take one wait state so a write just before is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (take && !hwrite) begin
                hreadyout <= 1'b0;
            end else if (rd_pend_q) begin
                hreadyout <= 1'b1;
                hrdata <= {24'h000000, rd_mux};
            end
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        if (addr_ok_q) begin
            case (addr_q)
                IDX_TIMER_CONTROL: rd_mux = ctl_q;
                IDX_TIMER_MODE: rd_mux = mod_q;
                IDX_COUNT_LOW_ZERO: rd_mux = lo0_q;
                IDX_COUNT_HIGH_ZERO: rd_mux = hi0_q;
                IDX_COUNT_LOW_ONE: rd_mux = lo1_q;
                IDX_COUNT_HIGH_ONE: rd_mux = hi1_q;
                IDX_SLEEP_CTRL: rd_mux = {6'h00, slp_q};
                default: rd_mux = 8'h00;
            endcase
        end
    end

    function automatic logic wr_hit(input logic [7:0] idx);
        wr_hit = wr_pend_q && addr_ok_q && (addr_q == idx);
    endfunction

    assign wr_ctl = wr_hit(IDX_TIMER_CONTROL);
    assign wr_mod = wr_hit(IDX_TIMER_MODE);
    assign wr_lo0 = wr_hit(IDX_COUNT_LOW_ZERO);
    assign wr_hi0 = wr_hit(IDX_COUNT_HIGH_ZERO);
    assign wr_lo1 = wr_hit(IDX_COUNT_LOW_ONE);
    assign wr_hi1 = wr_hit(IDX_COUNT_HIGH_ONE);
    assign wr_slp = wr_hit(IDX_SLEEP_CTRL);

    // ********************************************
    // machine cycle phases
    // ********************************************
    logic [3:0] phase_q;
    logic asleep;
    logic phase_three;
    logic phase_five;

    assign asleep = slp_q[SLP_SOFT] || slp_q[SLP_HARD];

    // the oscillator is stopped in sleep, so the phase counter freezes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= 4'h0;
        end else if (!asleep) begin
            phase_q <= (phase_q == PHASE_LAST) ? 4'h0 : phase_q + 4'h1;
        end
    end

    assign phase_three = !asleep && (phase_q == PHASE_S3);
    assign phase_five = !asleep && (phase_q == PHASE_S5);

    // ********************************************
    // external count detectors
    // ********************************************
    logic [1:0] pin_prev_q;
    logic [1:0] edge_latch_q;
    logic [1:0] sync_latch_q;
    logic [1:0] pin_fall;
    logic [1:0] ext_tick;

    assign pin_fall = pin_prev_q & ~pins.count_pin;

    // pins are taken as synchronous; each falling edge is caught once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_prev_q <= 2'b11;
        end else begin
            pin_prev_q <= pins.count_pin;
        end
    end

    // a fresh edge wins over the clear by the count pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_latch_q <= 2'b00;
            sync_latch_q <= 2'b00;
        end else begin
            edge_latch_q <= (edge_latch_q & ~(sync_latch_q &
                {2{phase_three}})) | pin_fall;
            if (phase_five) begin
                sync_latch_q <= edge_latch_q;
            end
        end
    end

    // slow pin phases are needed to not miss edges
    assign ext_tick = asleep ? pin_fall
        : (sync_latch_q & {2{phase_three}});

    // ********************************************
    // counting
    // ********************************************
    function automatic dtc_cnt_s step(input logic [7:0] lo,
                                      input logic [7:0] hi,
                                      input dtc_mode_e md);
        dtc_cnt_s r;
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        r.lo = lo;
        r.hi = hi;
        r.carry = 1'b0;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        case (md)
            MODE_13BIT: begin
                r.lo = {lo[7:5], s13[4:0]};
                r.hi = s13[12:5];
                r.carry = s13[13];
            end
            MODE_16BIT: begin
                r.lo = s16[7:0];
                r.hi = s16[15:8];
                r.carry = s16[16];
            end
            MODE_RELOAD: begin
                r.lo = s8[8] ? hi : s8[7:0];
                r.carry = s8[8];
            end
            MODE_SPLIT: begin
                r.lo = s8[7:0];
                r.carry = s8[8];
            end
            default: r = {lo, hi, 1'b0};
        endcase
        return r;
    endfunction

    dtc_mode_e md0;
    dtc_mode_e md1;
    dtc_cnt_s st0;
    dtc_cnt_s st1;
    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc_hi0;
    logic car0;
    logic car1;
    logic car_hi0;
    logic [8:0] hi0_sum;

    assign md0 = dtc_mode_e'(mod_q[MOD_MODE0_LSB +: 2]);
    assign md1 = dtc_mode_e'(mod_q[MOD_MODE1_LSB +: 2]);

    assign run0 = ctl_q[CTL_RUN_ZERO] && (!mod_q[MOD_GATE0]
        || pins.gate_pin[0]);
    assign run1 = ctl_q[CTL_RUN_ONE] && (!mod_q[MOD_GATE1]
        || pins.gate_pin[1]);

    assign inc0 = run0 && (mod_q[MOD_SRC0] ? ext_tick[0]
        : phase_three);
    assign inc1 = run1 && (md1 != MODE_SPLIT) && (mod_q[MOD_SRC1]
        ? ext_tick[1] : phase_three);

    // split high byte runs on the internal clock under run one only
    assign inc_hi0 = (md0 == MODE_SPLIT) && ctl_q[CTL_RUN_ONE]
        && phase_three;
    assign hi0_sum = {1'b0, hi0_q} + 9'h001;

    assign st0 = step(lo0_q, hi0_q, md0);
    assign st1 = step(lo1_q, hi1_q, md1);
    assign car0 = inc0 && st0.carry;
    assign car1 = inc1 && st1.carry;
    assign car_hi0 = inc_hi0 && hi0_sum[8];

    // timer zero bytes; a bus write beats the increment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lo0_q <= RST_BYTE;
            hi0_q <= RST_BYTE;
        end else begin
            if (wr_lo0) begin
                lo0_q <= wd;
            end else if (inc0) begin
                lo0_q <= st0.lo;
            end
            if (wr_hi0) begin
                hi0_q <= wd;
            end else if (inc_hi0) begin
                hi0_q <= hi0_sum[7:0];
            end else if (inc0 && md0 != MODE_SPLIT) begin
                hi0_q <= st0.hi;
            end
        end
    end

    // timer one bytes, independent of timer zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lo1_q <= RST_BYTE;
            hi1_q <= RST_BYTE;
        end else begin
            if (wr_lo1) begin
                lo1_q <= wd;
            end else if (inc1) begin
                lo1_q <= st1.lo;
            end
            if (wr_hi1) begin
                hi1_q <= wd;
            end else if (inc1) begin
                hi1_q <= st1.hi;
            end
        end
    end

    // ********************************************
    // control, mode and sleep registers
    // ********************************************
    // hardware set of a flag wins over a same-cycle software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= RST_BYTE;
        end else begin
            if (wr_ctl) begin
                ctl_q <= wd;
            end
            if (car0) begin
                ctl_q[CTL_OVF_ZERO] <= 1'b1;
            end
            if (car1 || car_hi0) begin
                ctl_q[CTL_OVF_ONE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mod_q <= RST_BYTE;
        end else if (wr_mod) begin
            mod_q <= wd;
        end
    end

    logic wake;

    assign wake = asleep && ((car0 && mod_q[MOD_SRC0])
        || (car1 && mod_q[MOD_SRC1]));

    // wake-up clears both sleep bits and overrides a same-cycle write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slp_q <= 2'b00;
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= wake;
            if (wake) begin
                slp_q <= 2'b00;
            end else if (wr_slp) begin
                slp_q <= wd[1:0];
            end
        end
    end

    // ********************************************
    // serial clock output
    // ********************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_clk_tick <= 1'b0;
        end else begin
            serial_clk_tick <= car1;
        end
    end

endmodule
`default_nettype wire

// ### dv/dtc_top_checker.sv
// assertion checker for the timer block bus and pulse outputs
`timescale 1ns/1ns
`default_nettype none
module dtc_top_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic serial_clk_tick,
    input wire logic wake_pulse
);
    // ****************************************
    // bus timing and pulse spacing
    // ****************************************
    wire rd_go = hsel & htrans[1] & hready & !hwrite;
    wire wr_go = hsel & htrans[1] & hready & hwrite;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_rd_taken;
        rd_go;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_one_wait: assert property (s_rd_taken |=> s_one_wait)
        else $error("read did not take exactly one wait state");
    a_write_no_wait: assert property (wr_go |=> hreadyout)
        else $error("write inserted a wait state");
    a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_go))
        else $error("wait state without a read");
    a_rdata_held: assert property ($changed(hrdata)
        |-> !$past(hreadyout))
        else $error("read data moved outside a read");
    a_okay_only: assert property (!hresp)
        else $error("response other than okay");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    // carries come at most once per machine cycle
    a_tick_spaced: assert property (serial_clk_tick
        |=> !serial_clk_tick [*8])
        else $error("serial tick pulses too close");
    a_wake_spaced: assert property (wake_pulse |=> !wake_pulse [*8])
        else $error("wake pulses too close");
endmodule

bind dtc_top dtc_top_checker u_dtc_top_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .serial_clk_tick(serial_clk_tick),
    .wake_pulse(wake_pulse)
);
`default_nettype wire

// ### dv/dtc_pin_model.sv
// model of the external count and gate pins
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_model
    import dtc_pkg::*;
(
    input wire logic hclk,
    output var dtc_pins_s pins
);
    // ****************************************
    // pin drivers
    // ****************************************
    // count pins idle high, as behind a pull-up
    initial pins = '{count_pin: 2'b11, gate_pin: 2'b00};
    task automatic pulse(input logic [1:0] which);
        @(posedge hclk);
        pins.count_pin <= ~which;
        repeat (12) @(posedge hclk);
        pins.count_pin <= 2'b11;
        repeat (12) @(posedge hclk);
    endtask
    task automatic set_gate(input logic [1:0] g);
        @(posedge hclk);
        pins.gate_pin <= g;
    endtask
endmodule
`default_nettype wire

// ### dv/tb_dual_timer_counter_modes.sv
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ns
`default_nettype none
module tb_dual_timer_counter_modes
    import dtc_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic tick;
    logic wake;
    dtc_pins_s pins;
    int num_errors = 0;
    int n_tests = 0;
    int n_tick = 0;
    int n_wake = 0;
    always #5 hclk = ~hclk;
    dtc_top u_dtc_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pins(pins), .serial_clk_tick(tick),
        .wake_pulse(wake)
    );
    dtc_pin_model u_dtc_pin_model (.hclk(hclk), .pins(pins));
    always @(posedge hclk) begin
        if (tick === 1'b1) n_tick <= n_tick + 1;
        if (wake === 1'b1) n_wake <= n_wake + 1;
    end
    // ****************************************
    // bus and check tasks
    // ****************************************
    task automatic summarize();
        $display("mismatches %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // ready is judged half a cycle early so the edge never races it
    task automatic ready(output logic [7:0] r);
        int k;
        k = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && k < 20) begin
            @(negedge hclk);
            k++;
        end
        if (hreadyout !== 1'b1) begin
            num_errors++;
            summarize();
        end
        r = hrdata[7:0];
        @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        hsel <= 1'b1;
        hsize <= 3'h2;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        ready(r);
        // select only qualifies the address phase, so drop it here
        hsel <= 1'b0;
        hsize <= 3'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        ready(r);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, {22'h0, idx, 2'b00}, d, r);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, {22'h0, idx, 2'b00}, 8'h00, r);
        cmp(r, e);
    endtask
    // run for exactly n machine cycles, then stop and read the bytes back
    task automatic cnt(input int t, input logic [7:0] md, ctl, lo, hi,
                       input int n, input logic [7:0] elo, ehi);
        wr(IDX_TIMER_MODE, md);
        wr(IDX_COUNT_LOW_ZERO + 8'(2 * t), lo);
        wr(IDX_COUNT_HIGH_ZERO + 8'(2 * t), hi);
        wr(IDX_TIMER_CONTROL, ctl);
        repeat (12 * n - 2) @(posedge hclk);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rdc(IDX_COUNT_LOW_ZERO + 8'(2 * t), elo);
        rdc(IDX_COUNT_HIGH_ZERO + 8'(2 * t), ehi);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int i;
        int c;
        logic [7:0] r;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (i = 0; i < 7; i++) begin
            rdc(IDX_TIMER_CONTROL + 8'(i), RST_BYTE);
        end
        bus(1'b1, 32'h0000_0620, 8'hFF, r);
        bus(1'b0, 32'h0000_0620, 8'h00, r);
        cmp(r, 8'h00);
        rdc(IDX_TIMER_CONTROL, 8'h00);
        wr(IDX_TIMER_CONTROL, 8'h0F);
        rdc(IDX_TIMER_CONTROL, 8'h0F);
        wr(IDX_COUNT_HIGH_ONE, 8'hA5);
        rdc(IDX_COUNT_HIGH_ONE, 8'hA5);
        wr(IDX_TIMER_MODE, 8'hC3);
        rdc(IDX_TIMER_MODE, 8'hC3);
        cnt(0, 8'h01, 8'h10, 8'hFE, 8'hFF, 3, 8'h01, 8'h00);
        cnt(0, 8'h01, 8'h00, 8'h05, 8'h00, 2, 8'h05, 8'h00);
        cnt(0, 8'h00, 8'h10, 8'hFF, 8'hFF, 1, 8'hE0, 8'h00);
        c = n_tick;
        cnt(1, 8'h20, 8'h40, 8'hFE, 8'hFD, 3, 8'hFE, 8'hFD);
        cmp(8'(n_tick - c), 8'h01);
        cnt(0, 8'h03, 8'h40, 8'h11, 8'hFF, 1, 8'h11, 8'h00);
        cnt(1, 8'h30, 8'h40, 8'h22, 8'h33, 2, 8'h22, 8'h33);
        u_dtc_pin_model.set_gate(2'b00);
        cnt(0, 8'h09, 8'h10, 8'h00, 8'h00, 2, 8'h00, 8'h00);
        cnt(0, 8'h01, 8'h10, 8'h00, 8'h00, 2, 8'h02, 8'h00);
        u_dtc_pin_model.set_gate(2'b01);
        cnt(0, 8'h09, 8'h10, 8'h00, 8'h00, 2, 8'h02, 8'h00);
        wr(IDX_TIMER_MODE, 8'h01);
        wr(IDX_COUNT_LOW_ZERO, 8'hFF);
        wr(IDX_COUNT_HIGH_ZERO, 8'hFF);
        wr(IDX_TIMER_CONTROL, 8'h10);
        repeat (24) @(posedge hclk);
        rdc(IDX_TIMER_CONTROL, 8'h30);
        wr(IDX_TIMER_MODE, 8'h55);
        for (i = 0; i < 4; i++) begin
            wr(IDX_COUNT_LOW_ZERO + 8'(i), 8'h00);
        end
        wr(IDX_TIMER_CONTROL, 8'h50);
        u_dtc_pin_model.pulse(2'b11);
        u_dtc_pin_model.pulse(2'b11);
        u_dtc_pin_model.pulse(2'b01);
        repeat (12) @(posedge hclk);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rdc(IDX_COUNT_LOW_ZERO, 8'h03);
        rdc(IDX_COUNT_LOW_ONE, 8'h02);
        // soft then hard sleep, each cancelled by a pin-driven carry
        for (i = 1; i < 3; i++) begin
            wr(IDX_TIMER_MODE, 8'h05);
            wr(IDX_COUNT_LOW_ZERO, 8'hFF);
            wr(IDX_COUNT_HIGH_ZERO, 8'hFF);
            wr(IDX_TIMER_CONTROL, 8'h10);
            wr(IDX_SLEEP_CTRL, 8'(i));
            c = n_wake;
            u_dtc_pin_model.pulse(2'b01);
            rdc(IDX_SLEEP_CTRL, 8'h00);
            rdc(IDX_COUNT_HIGH_ZERO, 8'h00);
            cmp(8'(n_wake - c), 8'h01);
        end
        summarize();
    end
endmodule
`default_nettype wire
